// [rtl/fast_threshold_overrange_detect.sv]
`timescale 1ns/10ps
`include "fast_detect_defs.svh"
module fast_threshold_overrange_detect
#(
	parameter int LOWER_DELAY = `LOWER_PIPE_DEPTH
)
(
	input  wire logic                   clk,
	input  wire logic                   reset_n,
	input  fast_detect_pkg::sample_t    sampleA,
	input  fast_detect_pkg::sample_t    sampleB,
	input  wire logic                   overrangeA,
	input  wire logic                   overrangeB,
	input  wire logic [3:0]             vcOverrange,
	input  wire logic                   regWriteEn,
	input  fast_detect_pkg::reg_addr_t  regAddr,
	input  fast_detect_pkg::reg_byte_t  regWriteData,
	output fast_detect_pkg::reg_byte_t  regReadData,
	output logic                        flagPinChanA,
	output logic                        flagPinChanB,
	output fast_detect_pkg::link_word_t linkWordA,
	output fast_detect_pkg::link_word_t linkWordB
);
	import fast_detect_pkg::*;

	// Each lower path stage is 13 flops per channel; long chains cost area
	if (LOWER_DELAY < 1 || LOWER_DELAY > 24)
		$error("LOWER_DELAY out of range");

	localparam int fdMaxCycles = `FD_LATENCY_MAX;

	mag_t       upper_reg, upper_next;
	mag_t       lower_reg, lower_next;
	dwell_t     dwell_reg, dwell_next;
	logic [1:0] cbCount_reg, cbCount_next;
	logic       flagCbEn_reg, flagCbEn_next;
	logic [3:0] orClear_reg, orClear_next;
	reg_byte_t  readData_reg, readData_next;
	logic       pinA_reg, pinA_next;
	logic       pinB_reg, pinB_next;
	link_word_t linkA_reg, linkA_next;
	link_word_t linkB_reg, linkB_next;
	logic       flagA, flagB;
	logic [3:0] sticky;

	threshold_cfg_if cfg ();

	// Control bits fill from the MSB end; sample and overrange share a stage
	function automatic link_word_t buildLink(input sample_t s, input logic ovr,
		input logic flag, input logic [1:0] cnt, input logic en);
		logic cb1;
		logic cb0;
		cb1 = (cnt != 2'h0) ? ovr : 1'b0;
		cb0 = (cnt >= 2'h2) ? (flag & en) : 1'b0;
		buildLink = {s, cb1, cb0};
	endfunction : buildLink

	////////////////////////////////////////////////////////////////////////
	// Configuration registers
	always_comb
	begin
		upper_next    = upper_reg;
		lower_next    = lower_reg;
		dwell_next    = dwell_reg;
		cbCount_next  = cbCount_reg;
		flagCbEn_next = flagCbEn_reg;
		orClear_next  = orClear_reg;
		if (regWriteEn)
		begin
			unique case (regAddr)
				`UPPER_LO_ADDR: upper_next[7:0] = regWriteData;
				`UPPER_HI_ADDR: upper_next[12:8] = regWriteData[`THRESH_HI_MSB:0];
				`LOWER_LO_ADDR: lower_next[7:0] = regWriteData;
				`LOWER_HI_ADDR: lower_next[12:8] = regWriteData[`THRESH_HI_MSB:0];
				`DWELL_LO_ADDR: dwell_next[7:0] = regWriteData;
				`DWELL_HI_ADDR: dwell_next[15:8] = regWriteData;
				`CB_CFG_ADDR:
					cbCount_next = regWriteData[`CB_COUNT_MSB:`CB_COUNT_LSB];
				`CB_FLAG_ADDR: flagCbEn_next = regWriteData[`FLAG_CB_EN_BIT];
				`OR_CLEAR_ADDR: orClear_next = regWriteData[3:0];
				default: ;
			endcase
		end
		unique case (regAddr)
			`UPPER_LO_ADDR:  readData_next = upper_reg[7:0];
			`UPPER_HI_ADDR:  readData_next = {3'h0, upper_reg[12:8]};
			`LOWER_LO_ADDR:  readData_next = lower_reg[7:0];
			`LOWER_HI_ADDR:  readData_next = {3'h0, lower_reg[12:8]};
			`DWELL_LO_ADDR:  readData_next = dwell_reg[7:0];
			`DWELL_HI_ADDR:  readData_next = dwell_reg[15:8];
			`CB_CFG_ADDR:    readData_next = {6'h00, cbCount_reg};
			`CB_FLAG_ADDR:   readData_next = {7'h00, flagCbEn_reg};
			`OR_CLEAR_ADDR:  readData_next = {4'h0, orClear_reg};
			`OR_STATUS_ADDR: readData_next = {4'h0, sticky};
			default:         readData_next = 8'h00;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			upper_reg    <= `UPPER_RESET;
			lower_reg    <= `LOWER_RESET;
			dwell_reg    <= `DWELL_RESET;
			cbCount_reg  <= `CB_COUNT_RESET;
			flagCbEn_reg <= `FLAG_CB_RESET;
			orClear_reg  <= `OR_CLEAR_RESET;
			readData_reg <= 8'h00;
		end
		else
		begin
			upper_reg    <= upper_next;
			lower_reg    <= lower_next;
			dwell_reg    <= dwell_next;
			cbCount_reg  <= cbCount_next;
			flagCbEn_reg <= flagCbEn_next;
			orClear_reg  <= orClear_next;
			readData_reg <= readData_next;
		end
	end

	assign cfg.upperThresh = upper_reg;
	assign cfg.lowerThresh = lower_reg;
	assign cfg.dwellTime   = dwell_reg;

	////////////////////////////////////////////////////////////////////////
	// Detectors, sticky status, link words
	fast_detect_channel #(.LOWER_DELAY(LOWER_DELAY)) detectA
	(
		.clk      (clk),
		.reset_n  (reset_n),
		.sample   (sampleA),
		.cfg      (cfg.sink),
		.fastFlag (flagA)
	);

	fast_detect_channel #(.LOWER_DELAY(LOWER_DELAY)) detectB
	(
		.clk      (clk),
		.reset_n  (reset_n),
		.sample   (sampleB),
		.cfg      (cfg.sink),
		.fastFlag (flagB)
	);

	overrange_tracker tracker
	(
		.clk         (clk),
		.reset_n     (reset_n),
		.vcOverrange (vcOverrange),
		.clearBits   (orClear_reg),
		.sticky      (sticky)
	);

	always_comb
	begin
		linkA_next = buildLink(sampleA, overrangeA, flagA, cbCount_reg, flagCbEn_reg);
		linkB_next = buildLink(sampleB, overrangeB, flagB, cbCount_reg, flagCbEn_reg);
		// Pins leave from flops so gain control sees clean levels
		pinA_next  = flagA;
		pinB_next  = flagB;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			pinA_reg  <= 1'b0;
			pinB_reg  <= 1'b0;
			linkA_reg <= 16'h0000;
			linkB_reg <= 16'h0000;
		end
		else
		begin
			pinA_reg  <= pinA_next;
			pinB_reg  <= pinB_next;
			linkA_reg <= linkA_next;
			linkB_reg <= linkB_next;
		end
	end

	assign regReadData  = readData_reg;
	assign flagPinChanA = pinA_reg;
	assign flagPinChanB = pinB_reg;
	assign linkWordA    = linkA_reg;
	assign linkWordB    = linkB_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks on pins, link words and register traffic
	// Latency is only asked while the upper threshold holds still
	AST_UPPER_LATENCY:
	assert property (@(posedge clk) disable iff (!reset_n)
		(absMag(sampleA) > upper_reg) && $stable(upper_reg)
			|-> ##[1:fdMaxCycles] flagPinChanA)
		else $error("upper detect too slow");

	AST_OVR_ALIGN:
	assert property (@(posedge clk) disable iff (!reset_n)
		cbCount_reg != 2'h0 |=> linkWordA[15:2] == $past(sampleA)
			&& linkWordA[1] == $past(overrangeA))
		else $error("overrange misaligned with sample");

	AST_CB_ZERO:
	assert property (@(posedge clk) disable iff (!reset_n)
		cbCount_reg == 2'h0 |=> linkWordA[1:0] == 2'h0 && linkWordB[1:0] == 2'h0)
		else $error("control bits present with zero count");

	AST_FLAG_CB_OFF:
	assert property (@(posedge clk) disable iff (!reset_n)
		!flagCbEn_reg |=> !linkWordA[0] && !linkWordB[0])
		else $error("flag control bit while disabled");

	AST_UPPER_LATENCY_B:
	assert property (@(posedge clk) disable iff (!reset_n)
		(absMag(sampleB) > upper_reg) && $stable(upper_reg)
			|-> ##[1:fdMaxCycles] flagPinChanB)
		else $error("upper detect too slow on channel B");

	AST_OVR_ALIGN_B:
	assert property (@(posedge clk) disable iff (!reset_n)
		cbCount_reg != 2'h0 |=> linkWordB[15:2] == $past(sampleB)
			&& linkWordB[1] == $past(overrangeB))
		else $error("overrange misaligned with sample on channel B");

	// One control bit carries the overrange; the flag needs a second one
	AST_CB_ONE:
	assert property (@(posedge clk) disable iff (!reset_n)
		cbCount_reg == 2'h1 |=> !linkWordA[0] && !linkWordB[0])
		else $error("second control bit present with a count of one");

	AST_FLAG_CB_ON:
	assert property (@(posedge clk) disable iff (!reset_n)
		flagCbEn_reg && cbCount_reg >= 2'h2 |=> linkWordA[0] == flagPinChanA)
		else $error("flag control bit missing on channel A");

	AST_FLAG_CB_ON_B:
	assert property (@(posedge clk) disable iff (!reset_n)
		flagCbEn_reg && cbCount_reg >= 2'h2 |=> linkWordB[0] == flagPinChanB)
		else $error("flag control bit missing on channel B");

	// Register writes land one edge after the strobe
	AST_UPPER_WRITE:
	assert property (@(posedge clk) disable iff (!reset_n)
		regWriteEn && regAddr == `UPPER_LO_ADDR |=> upper_reg[7:0] == $past(regWriteData))
		else $error("upper threshold low byte not written");

	AST_UPPER_HI_WRITE:
	assert property (@(posedge clk) disable iff (!reset_n)
		regWriteEn && regAddr == `UPPER_HI_ADDR
			|=> upper_reg[12:8] == $past(regWriteData[`THRESH_HI_MSB:0]))
		else $error("upper threshold high byte not written");

	AST_LOWER_WRITE:
	assert property (@(posedge clk) disable iff (!reset_n)
		regWriteEn && regAddr == `LOWER_LO_ADDR |=> lower_reg[7:0] == $past(regWriteData))
		else $error("lower threshold low byte not written");

	AST_LOWER_HI_WRITE:
	assert property (@(posedge clk) disable iff (!reset_n)
		regWriteEn && regAddr == `LOWER_HI_ADDR
			|=> lower_reg[12:8] == $past(regWriteData[`THRESH_HI_MSB:0]))
		else $error("lower threshold high byte not written");

	AST_THRESH_HI_MASK:
	assert property (@(posedge clk) disable iff (!reset_n)
		regAddr == `UPPER_HI_ADDR || regAddr == `LOWER_HI_ADDR |=> regReadData[7:5] == 3'h0)
		else $error("threshold high byte shows bits above the 13-bit value");

	AST_DWELL_WRITE:
	assert property (@(posedge clk) disable iff (!reset_n)
		regWriteEn && regAddr == `DWELL_HI_ADDR |=> dwell_reg[15:8] == $past(regWriteData))
		else $error("dwell time high byte not written");

	AST_CB_EN_WRITE:
	assert property (@(posedge clk) disable iff (!reset_n)
		regWriteEn && regAddr == `CB_FLAG_ADDR
			|=> flagCbEn_reg == $past(regWriteData[`FLAG_CB_EN_BIT]))
		else $error("flag control bit enable not written");

	AST_CLEAR_WRITE:
	assert property (@(posedge clk) disable iff (!reset_n)
		regWriteEn && regAddr == `OR_CLEAR_ADDR |=> orClear_reg == $past(regWriteData[3:0]))
		else $error("overrange clear not written");

	AST_CLEAR_HOLD:
	assert property (@(posedge clk) disable iff (!reset_n)
		orClear_reg != 4'h0 && vcOverrange == 4'h0 |=> (sticky & $past(orClear_reg)) == 4'h0)
		else $error("sticky bit kept while its clear is held");

	AST_STATUS_READ:
	assert property (@(posedge clk) disable iff (!reset_n)
		regAddr == `OR_STATUS_ADDR |=> regReadData == {4'h0, $past(sticky)})
		else $error("sticky status read back wrong");
endmodule : fast_threshold_overrange_detect

// [rtl/fast_detect_defs.svh]
`ifndef FAST_DETECT_DEFS_SVH
`define FAST_DETECT_DEFS_SVH
// Register offsets
`define UPPER_LO_ADDR   12'h247
`define UPPER_HI_ADDR   12'h248
`define LOWER_LO_ADDR   12'h249
`define LOWER_HI_ADDR   12'h24A
`define DWELL_LO_ADDR   12'h24B
`define DWELL_HI_ADDR   12'h24C
`define CB_CFG_ADDR     12'h559
`define CB_FLAG_ADDR    12'h55A
`define OR_CLEAR_ADDR   12'h562
`define OR_STATUS_ADDR  12'h563
// Field positions
`define CB_COUNT_MSB    1
`define CB_COUNT_LSB    0
`define FLAG_CB_EN_BIT  0
`define THRESH_HI_MSB   4
// Reset values
`define UPPER_RESET     13'h1FFF
`define LOWER_RESET     13'h0000
`define DWELL_RESET     16'h0001
`define CB_COUNT_RESET  2'h0
`define FLAG_CB_RESET   1'h0
`define OR_CLEAR_RESET  4'h0
// Timing counts, in sample clock cycles
`define FD_LATENCY_MAX  28
`define LOWER_PIPE_DEPTH 4
`endif

// [rtl/fast_detect_pkg.sv]
package fast_detect_pkg;
	typedef logic [12:0]        mag_t;
	typedef logic signed [13:0] sample_t;
	typedef logic [15:0]        dwell_t;
	typedef logic [11:0]        reg_addr_t;
	typedef logic [7:0]         reg_byte_t;
	typedef logic [15:0]        link_word_t;

	// Negative full scale saturates so the result always fits 13 bits
	function automatic mag_t absMag(input sample_t s);
		logic [13:0] a;
		a = s[13] ? 14'(-s) : 14'(s);
		absMag = a[13] ? 13'h1FFF : a[12:0];
	endfunction : absMag
endpackage : fast_detect_pkg

// [rtl/threshold_cfg_if.sv]
`timescale 1ns/10ps
interface threshold_cfg_if;
	import fast_detect_pkg::*;
	mag_t   upperThresh;
	mag_t   lowerThresh;
	dwell_t dwellTime;
	modport source (output upperThresh, output lowerThresh, output dwellTime);
	modport sink   (input upperThresh, input lowerThresh, input dwellTime);
endinterface : threshold_cfg_if

// [rtl/overrange_tracker.sv]
`timescale 1ns/10ps
module overrange_tracker
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic [3:0] vcOverrange,
	input  wire logic [3:0] clearBits,
	output logic      [3:0] sticky
);
	import fast_detect_pkg::*;

	logic [3:0] sticky_reg;
	logic [3:0] sticky_next;

	// Clear holds while the bit is set; a new overrange still wins
	always_comb
	begin
		sticky_next = (sticky_reg & ~clearBits) | vcOverrange;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
			sticky_reg <= 4'h0;
		else
			sticky_reg <= sticky_next;
	end

	assign sticky = sticky_reg;

	AST_STICKY_SET:
	assert property (@(posedge clk) disable iff (!reset_n)
		vcOverrange != 4'h0 |=> (sticky_reg & $past(vcOverrange)) == $past(vcOverrange))
		else $error("overrange not latched");

	AST_STICKY_KEEP:
	assert property (@(posedge clk) disable iff (!reset_n)
		##1 ($past(sticky_reg) & ~sticky_reg & ~$past(clearBits)) == 4'h0)
		else $error("sticky bit dropped without clear");
endmodule : overrange_tracker

// [rtl/fast_detect_channel.sv]
`timescale 1ns/10ps
`include "fast_detect_defs.svh"
module fast_detect_channel
#(
	parameter int LOWER_DELAY = `LOWER_PIPE_DEPTH
)
(
	input  wire logic                clk,
	input  wire logic                reset_n,
	input  fast_detect_pkg::sample_t sample,
	threshold_cfg_if.sink            cfg,
	output logic                     fastFlag
);
	import fast_detect_pkg::*;

	if (LOWER_DELAY < 1 || LOWER_DELAY > 24)
		$error("LOWER_DELAY out of range");

	mag_t        magStage_reg;
	mag_t        magStage_next;
	mag_t        magPipe_reg  [LOWER_DELAY];
	mag_t        magPipe_next [LOWER_DELAY];
	logic [16:0] dwellCount_reg;
	logic [16:0] dwellCount_next;
	logic        flag_reg;
	logic        flag_next;
	logic        aboveUpper;
	logic        belowLower;

	////////////////////////////////////////////////////////////////////////
	// Magnitude, early for the upper compare, delayed for the lower
	always_comb
	begin
		magStage_next = absMag(sample);
		magPipe_next[0] = magStage_reg;
		for (int i = 1; i < LOWER_DELAY; i++)
			magPipe_next[i] = magPipe_reg[i-1];
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			magStage_reg <= 13'h0000;
			for (int i = 0; i < LOWER_DELAY; i++)
				magPipe_reg[i] <= 13'h0000;
		end
		else
		begin
			magStage_reg <= magStage_next;
			magPipe_reg  <= magPipe_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Hysteresis: set at once, clear after the dwell
	assign aboveUpper = magStage_reg > cfg.upperThresh;
	assign belowLower = magPipe_reg[LOWER_DELAY-1] < cfg.lowerThresh;

	always_comb
	begin
		// A fresh set restarts the count too: the lower path lags the upper,
		// so a count left from older quiet samples would clear the flag at once
		if (!belowLower || aboveUpper)
			dwellCount_next = 17'h00000;
		else if (dwellCount_reg == 17'h1FFFF)
			dwellCount_next = dwellCount_reg;
		else
			dwellCount_next = dwellCount_reg + 17'h00001;
		flag_next = flag_reg;
		// Set outranks clear when both land in one cycle
		if (aboveUpper)
			flag_next = 1'b1;
		else if (dwellCount_reg > {1'b0, cfg.dwellTime})
			flag_next = 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			dwellCount_reg <= 17'h00000;
			flag_reg       <= 1'b0;
		end
		else
		begin
			dwellCount_reg <= dwellCount_next;
			flag_reg       <= flag_next;
		end
	end

	assign fastFlag = flag_reg;

	AST_FLAG_SET:
	assert property (@(posedge clk) disable iff (!reset_n) aboveUpper |=> flag_reg)
		else $error("flag not set above upper threshold");

	AST_FLAG_CLEAR:
	assert property (@(posedge clk) disable iff (!reset_n)
		$fell(flag_reg) |-> $past(dwellCount_reg) > {1'b0, $past(cfg.dwellTime)})
		else $error("flag cleared before dwell elapsed");

	AST_DWELL_RESTART:
	assert property (@(posedge clk) disable iff (!reset_n)
		!belowLower |=> dwellCount_reg == 17'h00000)
		else $error("dwell count not restarted");

	AST_LOWER_PIPE:
	assert property (@(posedge clk) disable iff (!reset_n)
		##LOWER_DELAY magPipe_reg[LOWER_DELAY-1] == $past(magStage_reg, LOWER_DELAY))
		else $error("lower compare path misaligned");

	AST_SET_RESTARTS_DWELL:
	assert property (@(posedge clk) disable iff (!reset_n)
		aboveUpper |=> dwellCount_reg == 17'h00000)
		else $error("dwell count kept across a new set");
endmodule : fast_detect_channel

// [verification/gain_ctrl_model.sv]
`timescale 1ns/10ps
// Gain control on the far side: one gain step per rising flag
module gain_ctrl_model
(
	input  wire logic       clk,
	input  wire logic       reset_n,
	input  wire logic       flagA,
	input  wire logic       flagB,
	output logic      [7:0] stepsA,
	output logic      [7:0] stepsB
);
	logic prevA_reg;
	logic prevB_reg;

	always @(posedge clk)
	begin
		if (!reset_n)
		begin
			{prevA_reg, prevB_reg, stepsA, stepsB} <= '0;
		end
		else
		begin
			prevA_reg <= flagA;
			prevB_reg <= flagB;
			// A flag that toggles would cost extra gain steps
			stepsA    <= stepsA + 8'(flagA & !prevA_reg);
			stepsB    <= stepsB + 8'(flagB & !prevB_reg);
		end
	end
endmodule : gain_ctrl_model

// [verification/fast_threshold_overrange_detect_tb.sv]
`timescale 1ns/10ps
module fast_threshold_overrange_detect_tb;
	import fast_detect_pkg::*;
	logic       clk, reset_n, overrangeA, overrangeB, regWriteEn;
	logic       flagPinChanA, flagPinChanB, rdNow, linkNow;
	logic [3:0] vcOverrange;
	logic [7:0] stepsA, stepsB;
	sample_t    sampleA, sampleB;
	reg_addr_t  regAddr;
	reg_byte_t  regWriteData, regReadData;
	link_word_t linkWordA, linkWordB;
	int         mismatches, n_compared, n;
	logic [31:0] rng;
	reg_byte_t  qRd[$];
	link_word_t qLink[$];
	link_word_t qLinkB[$];
	reg_addr_t  ra[9] = '{12'h247, 12'h248, 12'h249, 12'h24A, 12'h24B, 12'h24C, 12'h562,
		12'h563, 12'h100};
	reg_byte_t  rv[9] = '{8'hFF, 8'h1F, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00};

	fast_threshold_overrange_detect uut (.clk(clk), .reset_n(reset_n), .sampleA(sampleA),
		.sampleB(sampleB), .overrangeA(overrangeA), .overrangeB(overrangeB),
		.vcOverrange(vcOverrange), .regWriteEn(regWriteEn), .regAddr(regAddr),
		.regWriteData(regWriteData), .regReadData(regReadData), .flagPinChanA(flagPinChanA),
		.flagPinChanB(flagPinChanB), .linkWordA(linkWordA), .linkWordB(linkWordB));
	gain_ctrl_model partner (.clk(clk), .reset_n(reset_n), .flagA(flagPinChanA),
		.flagB(flagPinChanB), .stepsA(stepsA), .stepsB(stepsB));

	function automatic logic [31:0] xs();
		rng ^= rng << 13;
		rng ^= rng >> 17;
		rng ^= rng << 5;
		return rng;
	endfunction : xs

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic print_verdict();
		$display("mismatches %0d compared %0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : print_verdict

	task automatic wr(input reg_addr_t a, input reg_byte_t d);
		@(negedge clk);
		regAddr      = a;
		regWriteData = d;
		regWriteEn   = 1'b1;
		@(negedge clk);
		regWriteEn   = 1'b0;
	endtask : wr

	task automatic rd(input reg_addr_t a, input reg_byte_t e);
		@(negedge clk);
		regAddr = a;
		qRd.push_back(e);
		@(posedge clk);
		rdNow = 1'b1;
		@(negedge clk);
	endtask : rd

	// Bounded wait on the channel A pin; running out ends the run
	task automatic waitFlag(input logic lvl, input int lim);
		n = 0;
		while (flagPinChanA !== lvl)
		begin
			@(negedge clk);
			n++;
			if (n > lim)
			begin
				mismatches++;
				print_verdict();
			end
		end
	endtask : waitFlag

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(negedge clk)
	begin
		if (rdNow)
		begin
			check(16'(regReadData), 16'(qRd.pop_front()));
			rdNow = 1'b0;
		end
		if (linkNow)
		begin
			check(linkWordA, qLink.pop_front());
			check(linkWordB, qLinkB.pop_front());
		end
	end

	////////////////////////////////////////////////////////////////////////
	initial
	begin
		rng = 32'h3A86;
		{reset_n, overrangeA, overrangeB, regWriteEn, rdNow, linkNow} = '0;
		{sampleA, sampleB, vcOverrange, regAddr, regWriteData} = '0;
		{mismatches, n_compared} = '0;
		repeat (20) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		// Unmapped and read-only writes must leave no trace
		wr(12'h100, 8'hA5);
		wr(12'h563, 8'h0F);
		for (int i = 0; i < 9; i++)
			rd(ra[i], rv[i]);
		for (int i = 0; i < 6; i++)
		begin
			regWriteData = 8'(xs());
			wr(12'(12'h247 + i), regWriteData);
			rd(12'(12'h247 + i), (i == 1 || i == 3) ? regWriteData & 8'h1F : regWriteData);
		end
		// Full scale cannot exceed this upper, so the flag bit stays low
		wr(12'h247, 8'hFF);
		wr(12'h248, 8'h1F);
		wr(12'h55A, 8'h01);
		for (int c = 0; c < 4; c++)
		begin
			wr(12'h559, 8'(c));
			for (int j = 0; j < 8; j++)
			begin
				@(negedge clk);
				rng        = xs();
				sampleA    = rng[13:0];
				overrangeA = rng[14];
				overrangeB = rng[15];
				sampleB    = rng[29:16];
				qLink.push_back({sampleA, (c > 0) ? overrangeA : 1'b0, 1'b0});
				qLinkB.push_back({sampleB, (c > 0) ? overrangeB : 1'b0, 1'b0});
				@(posedge clk);
				linkNow = 1'b1;
			end
			@(negedge clk);
			@(posedge clk);
			linkNow = 1'b0;
		end
		////////////////////////////////////////////////////////////////////
		// Quiet inputs first, so no flag rises while thresholds are half written
		@(negedge clk);
		{sampleA, sampleB, overrangeA, overrangeB} = '0;
		wr(12'h247, 8'h00);
		wr(12'h248, 8'h01);
		wr(12'h249, 8'h80);
		wr(12'h24A, 8'h00);
		wr(12'h24B, 8'h0A);
		wr(12'h24C, 8'h00);
		@(negedge clk);
		{sampleB, overrangeA, overrangeB} = '0;
		sampleA = -14'sh101;
		@(negedge clk);
		sampleA = 14'sh7F;
		waitFlag(1'b1, 28);
		check(16'(flagPinChanB), 16'h0);
		check(16'(linkWordA[0]), 16'h1);
		wr(12'h55A, 8'h00);
		@(negedge clk);
		check(16'(linkWordA[0]), 16'h0);
		repeat (2) @(negedge clk);
		// Sample equal to lower must restart the dwell count
		sampleA = 14'sh80;
		@(negedge clk);
		sampleA = -14'sh7F;
		waitFlag(1'b0, 60);
		check(16'(n >= 11), 16'h1);
		check(16'(stepsA), 16'h1);
		check(16'(stepsB), 16'h0);
		////////////////////////////////////////////////////////////////////
		for (int v = 0; v < 4; v++)
		begin
			@(negedge clk);
			vcOverrange = 4'(1 << v);
			@(negedge clk);
			vcOverrange = 4'h0;
			rd(12'h563, 8'(1 << v));
			wr(12'h562, 8'(1 << v));
			wr(12'h562, 8'h00);
			rd(12'h563, 8'h00);
		end
		print_verdict();
	end

	initial
	begin
		#3000000;
		mismatches++;
		print_verdict();
	end
endmodule : fast_threshold_overrange_detect_tb
